// *** include/fsq_latch_if.sv ***
`timescale 1ns/1ps
interface fsq_latch_if;
    logic                                             load;
    logic                                             clear;
    logic [fsq_pkg::IDX_W-1:0]                        index;
    logic [fsq_pkg::WORD_W-1:0]                       data;
    logic [fsq_pkg::LATCHES-1:0][fsq_pkg::WORD_W-1:0] words;

    modport ctrl (output load, output clear, output index, output data,
                  input words);
    modport bank (input load, input clear, input index, input data,
                  output words);
endinterface : fsq_latch_if

// *** include/fsq_pkg.sv ***
package fsq_pkg;
    localparam int BYTE_W  = 8;
    localparam int WORD_W  = 14;
    localparam int ADDR_W  = 15;
    localparam int LATCHES = 32;
    localparam int IDX_W   = 5;
    localparam int BUS_AW  = 5;
    localparam int BUS_DW  = 32;
    localparam int TIMER_W = 24;
    localparam int SETUP_W = 2;

    localparam logic [BUS_AW-1:0] ADR_ADDR_LOW  = 5'h00;
    localparam logic [BUS_AW-1:0] ADR_ADDR_HIGH = 5'h04;
    localparam logic [BUS_AW-1:0] ADR_WORD_LOW  = 5'h08;
    localparam logic [BUS_AW-1:0] ADR_WORD_HIGH = 5'h0C;
    localparam logic [BUS_AW-1:0] ADR_CONTROL   = 5'h10;
    localparam logic [BUS_AW-1:0] ADR_UNLOCK    = 5'h14;

    localparam int CTRL_RD    = 0;
    localparam int CTRL_WR    = 1;
    localparam int CTRL_WEN   = 2;
    localparam int CTRL_ERR   = 3;
    localparam int CTRL_ERASE = 4;
    localparam int CTRL_LATCH = 5;
    localparam int CTRL_CFG   = 6;

    localparam logic [BYTE_W-1:0] UNLOCK_FIRST  = 8'h55;
    localparam logic [BYTE_W-1:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [BYTE_W-1:0] FILL_TOP      = 8'h80;
    localparam logic [WORD_W-1:0] BLANK_WORD    = 14'h3FFF;

    localparam int CLK_PERIOD_NS   = 40;
    localparam int ERASE_TIME_NS   = 2000000;
    localparam int PROGRAM_TIME_NS = 2000000;
    localparam int ERASE_CYCLES_DEF =
        (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES_DEF =
        (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYCLES = 2;

    typedef enum logic [1:0] {
        UL_IDLE      = 2'b00,
        UL_GOT_FIRST = 2'b01,
        UL_ARMED     = 2'b10
    } fsq_unlock_t;

    typedef enum logic [2:0] {
        OP_IDLE  = 3'b000,
        OP_READ  = 3'b001,
        OP_SETUP = 3'b010,
        OP_BUSY  = 3'b011,
        OP_DONE  = 3'b100
    } fsq_op_t;

    typedef enum logic [1:0] {
        KIND_LOAD    = 2'b00,
        KIND_ERASE   = 2'b01,
        KIND_PROGRAM = 2'b10
    } fsq_kind_t;
endpackage : fsq_pkg

// *** rtl/fsq_latch_bank.sv ***
`timescale 1ns/1ps
module fsq_latch_bank (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Latch access
    fsq_latch_if.bank lat
);
    genvar gi;
    generate
        for (gi = 0; gi < fsq_pkg::LATCHES; gi++) begin : g_latch
            logic [fsq_pkg::WORD_W-1:0] next_word;

            always_comb begin
                next_word = lat.words[gi];
                if (lat.clear) begin
                    next_word = fsq_pkg::BLANK_WORD;
                end else if (lat.load &&
                             lat.index == fsq_pkg::IDX_W'(gi)) begin
                    next_word = lat.data;
                end
            end

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    lat.words[gi] <= fsq_pkg::BLANK_WORD;
                end else begin
                    lat.words[gi] <= next_word;
                end
            end
        end
    endgenerate
endmodule : fsq_latch_bank

// *** rtl/fsq_sequencer.sv ***
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Function
// - Erase acts on one whole row, never a smaller unit.
// - Write-start is followed by two setup cycles shown as forced idles.
// - Row erase stalls the core for the erase time; clocks keep running.
// - After erase, the core resumes three instructions after write-start.
// - Programming never erases; software targets only blank words.
// - One program writes at most the 32 write latches.
// - Latches align to the row; low address bits select the latch.
// - Every completed program or erase resets all latches to blank.
// - Latches never loaded program the blank value.
// - With latch-only set, unlock loads only the addressed latch.
// - With latch-only clear, unlock loads the latch then programs all.
// - Latch load or program needs the full unlock sequence.
// - After the two idles of a commit the core stalls until done.
// - Write-start and read-start only set by software, cleared by hardware.
// - Reset during a write sets the error flag, kept across reset.
// - The unlock register reads as zero.
// - Data pair holds a 14-bit word, address pair a 15-bit address.
module fsq_sequencer #(
    parameter int ERASE_CYCLES   = fsq_pkg::ERASE_CYCLES_DEF,
    parameter int PROGRAM_CYCLES = fsq_pkg::PROGRAM_CYCLES_DEF
) (
    // Clock and resets
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic                        por_n,
    // Avalon-MM slave
    input  wire logic [fsq_pkg::BUS_AW-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [fsq_pkg::BUS_DW-1:0]  avs_writedata,
    output logic      [fsq_pkg::BUS_DW-1:0]  avs_readdata,
    output logic                             avs_waitrequest,
    // Core control
    output logic                             core_stall,
    output logic                             forced_nop,
    // Flash array
    output logic                             flash_read,
    input  wire logic [fsq_pkg::WORD_W-1:0]  flash_read_data,
    output logic                             flash_erase,
    output logic                             flash_program,
    output logic      [fsq_pkg::ADDR_W-1:0]  flash_address,
    output logic [fsq_pkg::LATCHES-1:0][fsq_pkg::WORD_W-1:0] flash_row_data
);
    fsq_latch_if lat ();

    fsq_latch_bank u_bank (
        .clock (clock),
        .rst_n (rst_n),
        .lat   (lat.bank)
    );

    // Register state
    logic [fsq_pkg::ADDR_W-1:0]  addr;
    logic [fsq_pkg::WORD_W-1:0]  word;
    logic                        read_start;
    logic                        write_start;
    logic                        write_enable;
    logic                        erase_select;
    logic                        latch_only;
    logic                        config_select;
    logic                        write_error_flag;
    logic [fsq_pkg::ADDR_W-1:0]  next_addr;
    logic [fsq_pkg::WORD_W-1:0]  next_word;
    logic                        next_read_start;
    logic                        next_write_start;
    logic                        next_write_enable;
    logic                        next_erase_select;
    logic                        next_latch_only;
    logic                        next_config_select;
    logic                        next_write_error_flag;
    logic [fsq_pkg::BUS_DW-1:0]  next_readdata;
    logic                        next_waitrequest;
    logic [fsq_pkg::BYTE_W-1:0]  rd8;
    logic [fsq_pkg::BYTE_W-1:0]  wd8;
    // Sequencer state
    fsq_pkg::fsq_unlock_t        unlock_state;
    fsq_pkg::fsq_unlock_t        next_unlock_state;
    fsq_pkg::fsq_op_t            op_state;
    fsq_pkg::fsq_op_t            next_op_state;
    fsq_pkg::fsq_kind_t          kind;
    fsq_pkg::fsq_kind_t          next_kind;
    logic [fsq_pkg::TIMER_W-1:0] timer;
    logic [fsq_pkg::TIMER_W-1:0] next_timer;
    logic [fsq_pkg::SETUP_W-1:0] setup_cnt;
    logic [fsq_pkg::SETUP_W-1:0] next_setup_cnt;
    logic                        acc;
    logic                        wr_acc;
    logic                        rd_acc;
    logic                        ws_req;
    logic                        start;
    logic                        rd_start;
    logic                        op_finish;
    logic                        writing;

    assign wd8    = avs_writedata[fsq_pkg::BYTE_W-1:0];
    assign acc    = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_acc = acc && avs_write;
    assign rd_acc = acc && avs_read;
    assign ws_req = wr_acc && avs_address == fsq_pkg::ADR_CONTROL &&
                    avs_writedata[fsq_pkg::CTRL_WR];
    // Start only straight after the two unlock writes, enabled, not config
    assign start  = ws_req && unlock_state == fsq_pkg::UL_ARMED &&
                    avs_writedata[fsq_pkg::CTRL_WEN] &&
                    !avs_writedata[fsq_pkg::CTRL_CFG];
    assign rd_start = wr_acc && avs_address == fsq_pkg::ADR_CONTROL &&
                      avs_writedata[fsq_pkg::CTRL_RD] && !start;
    assign writing  = op_state == fsq_pkg::OP_SETUP ||
                      op_state == fsq_pkg::OP_BUSY ||
                      op_state == fsq_pkg::OP_DONE;

    // Bus slave and software registers
    always_comb begin
        next_addr          = addr;
        next_word          = word;
        next_read_start    = read_start;
        next_write_start   = write_start;
        next_write_enable  = write_enable;
        next_erase_select  = erase_select;
        next_latch_only    = latch_only;
        next_config_select = config_select;
        next_waitrequest   = 1'b1;
        next_readdata      = avs_readdata;
        unique case (avs_address)
            fsq_pkg::ADR_ADDR_LOW:  rd8 = addr[fsq_pkg::BYTE_W-1:0];
            fsq_pkg::ADR_ADDR_HIGH: rd8 = fsq_pkg::FILL_TOP |
                fsq_pkg::BYTE_W'(addr[fsq_pkg::ADDR_W-1:fsq_pkg::BYTE_W]);
            fsq_pkg::ADR_WORD_LOW:  rd8 = word[fsq_pkg::BYTE_W-1:0];
            fsq_pkg::ADR_WORD_HIGH: rd8 =
                fsq_pkg::BYTE_W'(word[fsq_pkg::WORD_W-1:fsq_pkg::BYTE_W]);
            fsq_pkg::ADR_CONTROL:   rd8 = {1'b1, config_select, latch_only,
                erase_select, write_error_flag, write_enable, write_start,
                read_start};
            default:                rd8 = '0;
        endcase
        // Grant at most one access per two idle cycles; hold the core while busy
        if (avs_waitrequest && (avs_read || avs_write) &&
            op_state == fsq_pkg::OP_IDLE) begin
            next_waitrequest = 1'b0;
            next_readdata    = fsq_pkg::BUS_DW'(rd8);
        end
        if (wr_acc) begin
            unique case (avs_address)
                fsq_pkg::ADR_ADDR_LOW: next_addr =
                    {addr[fsq_pkg::ADDR_W-1:fsq_pkg::BYTE_W], wd8};
                fsq_pkg::ADR_ADDR_HIGH: next_addr =
                    {wd8[fsq_pkg::ADDR_W-fsq_pkg::BYTE_W-1:0],
                     addr[fsq_pkg::BYTE_W-1:0]};
                fsq_pkg::ADR_WORD_LOW: next_word =
                    {word[fsq_pkg::WORD_W-1:fsq_pkg::BYTE_W], wd8};
                fsq_pkg::ADR_WORD_HIGH: next_word =
                    {wd8[fsq_pkg::WORD_W-fsq_pkg::BYTE_W-1:0],
                     word[fsq_pkg::BYTE_W-1:0]};
                fsq_pkg::ADR_CONTROL: begin
                    next_write_enable  = avs_writedata[fsq_pkg::CTRL_WEN];
                    next_erase_select  = avs_writedata[fsq_pkg::CTRL_ERASE];
                    next_latch_only    = avs_writedata[fsq_pkg::CTRL_LATCH];
                    next_config_select = avs_writedata[fsq_pkg::CTRL_CFG];
                end
                default: ;
            endcase
        end
        // Start bits: software sets, only hardware clears
        if (rd_start) begin
            next_read_start = 1'b1;
        end else if (op_state == fsq_pkg::OP_READ) begin
            next_read_start = 1'b0;
            next_word       = flash_read_data;
        end
        if (start) begin
            next_write_start = 1'b1;
        end else if (op_finish) begin
            next_write_start = 1'b0;
            if (kind == fsq_pkg::KIND_ERASE) begin
                next_erase_select = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr            <= '0;
            word            <= '0;
            read_start      <= 1'b0;
            write_start     <= 1'b0;
            write_enable    <= 1'b0;
            erase_select    <= 1'b0;
            latch_only      <= 1'b0;
            config_select   <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else begin
            addr            <= next_addr;
            word            <= next_word;
            read_start      <= next_read_start;
            write_start     <= next_write_start;
            write_enable    <= next_write_enable;
            erase_select    <= next_erase_select;
            latch_only      <= next_latch_only;
            config_select   <= next_config_select;
            avs_waitrequest <= next_waitrequest;
            avs_readdata    <= next_readdata;
        end
    end

    // Error flag survives the core reset; power-on clears it, and a control write loads it from the written bit
    always_comb begin
        next_write_error_flag = write_error_flag;
        if (wr_acc && avs_address == fsq_pkg::ADR_CONTROL) begin
            next_write_error_flag = avs_writedata[fsq_pkg::CTRL_ERR];
        end
        if (!rst_n && writing) begin
            next_write_error_flag = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!por_n) begin
            write_error_flag <= 1'b0;
        end else begin
            write_error_flag <= next_write_error_flag;
        end
    end

    // Unlock tracker: any other access in between drops the sequence
    always_comb begin
        next_unlock_state = unlock_state;
        if (acc) begin
            next_unlock_state = fsq_pkg::UL_IDLE;
            if (wr_acc && avs_address == fsq_pkg::ADR_UNLOCK) begin
                if (wd8 == fsq_pkg::UNLOCK_FIRST) begin
                    next_unlock_state = fsq_pkg::UL_GOT_FIRST;
                end else if (wd8 == fsq_pkg::UNLOCK_SECOND &&
                             unlock_state == fsq_pkg::UL_GOT_FIRST) begin
                    next_unlock_state = fsq_pkg::UL_ARMED;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            unlock_state <= fsq_pkg::UL_IDLE;
        end else begin
            unlock_state <= next_unlock_state;
        end
    end

    // Operation sequencer and latch port
    always_comb begin
        next_op_state  = op_state;
        next_kind      = kind;
        next_timer     = timer;
        next_setup_cnt = setup_cnt;
        op_finish      = 1'b0;
        lat.load       = 1'b0;
        lat.clear      = 1'b0;
        lat.index      = addr[fsq_pkg::IDX_W-1:0];
        lat.data       = word;
        unique case (op_state)
            fsq_pkg::OP_IDLE: begin
                if (start) begin
                    next_op_state  = fsq_pkg::OP_SETUP;
                    next_setup_cnt =
                        fsq_pkg::SETUP_W'(fsq_pkg::SETUP_CYCLES - 1);
                    if (avs_writedata[fsq_pkg::CTRL_ERASE]) begin
                        next_kind = fsq_pkg::KIND_ERASE;
                    end else begin
                        lat.load = 1'b1;
                        next_kind = avs_writedata[fsq_pkg::CTRL_LATCH] ?
                            fsq_pkg::KIND_LOAD : fsq_pkg::KIND_PROGRAM;
                    end
                end else if (rd_start) begin
                    next_op_state = fsq_pkg::OP_READ;
                end
            end
            fsq_pkg::OP_READ: next_op_state = fsq_pkg::OP_IDLE;
            fsq_pkg::OP_SETUP: begin
                next_setup_cnt = setup_cnt - 1'b1;
                if (setup_cnt == '0) begin
                    if (kind == fsq_pkg::KIND_LOAD) begin
                        next_op_state = fsq_pkg::OP_IDLE;
                        op_finish     = 1'b1;
                    end else begin
                        next_op_state = fsq_pkg::OP_BUSY;
                        next_timer = (kind == fsq_pkg::KIND_ERASE) ?
                            fsq_pkg::TIMER_W'(ERASE_CYCLES - 1) :
                            fsq_pkg::TIMER_W'(PROGRAM_CYCLES - 1);
                    end
                end
            end
            fsq_pkg::OP_BUSY: begin
                next_timer = timer - 1'b1;
                if (timer == '0) begin
                    next_op_state = fsq_pkg::OP_DONE;
                end
            end
            fsq_pkg::OP_DONE: begin
                lat.clear     = 1'b1;
                op_finish     = 1'b1;
                next_op_state = fsq_pkg::OP_IDLE;
            end
            default: next_op_state = fsq_pkg::OP_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            op_state      <= fsq_pkg::OP_IDLE;
            kind          <= fsq_pkg::KIND_LOAD;
            timer         <= '0;
            setup_cnt     <= '0;
            core_stall    <= 1'b0;
            forced_nop    <= 1'b0;
            flash_read    <= 1'b0;
            flash_erase   <= 1'b0;
            flash_program <= 1'b0;
            flash_address <= '0;
        end else begin
            op_state      <= next_op_state;
            kind          <= next_kind;
            timer         <= next_timer;
            setup_cnt     <= next_setup_cnt;
            core_stall    <= next_op_state != fsq_pkg::OP_IDLE &&
                             next_op_state != fsq_pkg::OP_READ;
            forced_nop    <= next_op_state == fsq_pkg::OP_SETUP;
            flash_read    <= next_op_state == fsq_pkg::OP_READ;
            flash_erase   <= next_op_state == fsq_pkg::OP_BUSY &&
                             next_kind == fsq_pkg::KIND_ERASE;
            // All latches commit together; never more than one row
            flash_program <= next_op_state == fsq_pkg::OP_BUSY &&
                             next_kind == fsq_pkg::KIND_PROGRAM;
            flash_address <= next_addr;
        end
    end

    // Latch words go straight to the array; blank ones program blank
    assign flash_row_data = lat.words;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    unlock_reads_zero_a:
    assert property (rd_acc && avs_address == fsq_pkg::ADR_UNLOCK
                     |-> avs_readdata == '0)
        else $error("unlock register read not zero");
    setup_two_idles_a:
    assert property (start |=> forced_nop [*2] ##1 !forced_nop)
        else $error("setup idles not two cycles");
    erase_timer_a:
    assert property ($rose(flash_erase)
                     |-> timer == fsq_pkg::TIMER_W'(ERASE_CYCLES - 1))
        else $error("erase time not loaded");
    blank_after_done_a:
    assert property (op_state == fsq_pkg::OP_DONE |=>
        lat.words == {fsq_pkg::LATCHES{fsq_pkg::BLANK_WORD}})
        else $error("latches not blank after operation");
    unarmed_no_start_a:
    assert property (ws_req && unlock_state != fsq_pkg::UL_ARMED
                     |=> op_state != fsq_pkg::OP_SETUP)
        else $error("start without unlock");
    disabled_no_start_a:
    assert property (ws_req && !avs_writedata[fsq_pkg::CTRL_WEN]
                     |=> op_state != fsq_pkg::OP_SETUP)
        else $error("start without write enable");
    latch_only_a:
    assert property (start && next_kind == fsq_pkg::KIND_LOAD
        |=> !flash_program [*2] ##1
            (op_state == fsq_pkg::OP_IDLE && !flash_program && !write_start))
        else $error("latch-only load misbehaved");
    latch_loaded_a:
    assert property (lat.load |=> lat.words[$past(lat.index)] == $past(word))
        else $error("addressed latch not loaded");
    commit_program_a:
    assert property (start && next_kind == fsq_pkg::KIND_PROGRAM
                     |-> ##3 (flash_program && core_stall))
        else $error("commit did not program");
    stall_busy_a:
    assert property (flash_program || flash_erase
                     |-> core_stall && avs_waitrequest)
        else $error("core not stalled while busy");
    start_sticky_a:
    assert property (write_start && !op_finish |=> write_start)
        else $error("write-start cleared early");
    reset_error_a:
    assert property (@(posedge clock) disable iff (!por_n)
                     !rst_n && op_state == fsq_pkg::OP_BUSY
                     |=> write_error_flag)
        else $error("error flag not set by reset");

    erase_seen_c:   cover property ($fell(flash_erase));
    program_seen_c: cover property ($fell(flash_program));
    load_seen_c:    cover property (start && next_kind == fsq_pkg::KIND_LOAD);
    read_seen_c:    cover property (flash_read);
endmodule : fsq_sequencer

// *** tb/fsq_flash_model.sv ***
`timescale 1ns/1ps
module fsq_flash_model (
    // Clock
    input wire logic                          clock,
    // Array side
    input wire logic                          rd,
    output logic     [fsq_pkg::WORD_W-1:0]    rdata,
    input wire logic                          erase,
    input wire logic                          prog,
    input wire logic [31:0][13:0]             row,
    // Observation
    output logic     [31:0][13:0]             img,
    output int                                n_ops
);
    logic [13:0] pat = 14'h0155;
    logic        p_q = 1'b0;
    logic        e_q = 1'b0;
    // Word valid only in its read pulse, a moving pattern otherwise
    assign rdata = rd ? 14'h1ABC : pat;
    initial n_ops = 0;
    always @(posedge clock) begin
        pat <= ~pat;
        p_q <= prog;
        e_q <= erase;
        if (prog && !p_q) begin
            img   <= row;
            n_ops <= n_ops + 1;
        end
        if (erase && !e_q)
            n_ops <= n_ops + 1;
    end
endmodule : fsq_flash_model

// *** tb/tb_flash_self_write_sequencer.sv ***
`timescale 1ns/1ps
module tb_flash_self_write_sequencer;
    logic              clock = 0, rst_n = 0, por_n = 0, rd = 0, wr = 0;
    logic [4:0]        addr = '0;
    logic [31:0]       wdata = '0, rdata;
    logic              wait_q, stall, nop, frd, fer, fpr;
    logic [13:0]       frdata;
    logic [14:0]       fad;
    logic [31:0][13:0] row, img;
    logic [7:0]        q;
    int                n_ops, n_fail = 0, n_checks = 0, cyc = 0;
    logic [4:0] ta[6] = '{5'h00, 5'h04, 5'h0C, 5'h14, 5'h18, 5'h10};
    logic [7:0] td[6] = '{8'hA5, 8'hFF, 8'hFF, 8'h55, 8'hFF, 8'h06};
    logic [7:0] te[6] = '{8'hA5, 8'hFF, 8'h3F, 8'h00, 8'h00, 8'h84};
    fsq_sequencer #(.ERASE_CYCLES(20), .PROGRAM_CYCLES(20)) DUT (
        .clock(clock), .rst_n(rst_n), .por_n(por_n),
        .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wait_q), .core_stall(stall), .forced_nop(nop),
        .flash_read(frd), .flash_read_data(frdata), .flash_erase(fer),
        .flash_program(fpr), .flash_address(fad), .flash_row_data(row));
    fsq_flash_model u_flash (.clock(clock), .rd(frd), .rdata(frdata),
        .erase(fer), .prog(fpr), .row(row), .img(img), .n_ops(n_ops));
    initial forever #20 clock = ~clock;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic bus(input logic [4:0] a, input logic w,
                       input logic [7:0] d);
        addr  <= a;
        wr    <= w;
        rd    <= !w;
        wdata <= {24'h0, d};
        do @(posedge clock); while (wait_q !== 1'b0);
        q = rdata[7:0];
        rd <= 0;
        wr <= 0;
        @(posedge clock);
    endtask : bus
    task automatic unl(input logic [7:0] c);
        bus(fsq_pkg::ADR_UNLOCK, 1, 8'h55);
        bus(fsq_pkg::ADR_UNLOCK, 1, 8'hAA);
        bus(fsq_pkg::ADR_CONTROL, 1, c);
    endtask : unl
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1;
        por_n <= 1;
        @(posedge clock);
        foreach (ta[i]) begin
            bus(ta[i], 1, td[i]);
            bus(ta[i], 0, 8'h00);
            chk(q, te[i]);
        end
        $display("done: registers");
        bus(5'h00, 1, 8'h23);
        bus(5'h04, 1, 8'h00);
        bus(5'h08, 1, 8'h34);
        bus(5'h0C, 1, 8'h12);
        unl(8'h26);
        chk(nop, 1);
        chk(row[3], 14'h1234);
        chk(n_ops, 0);
        bus(5'h08, 1, 8'h11);
        bus(fsq_pkg::ADR_UNLOCK, 1, 8'h55);
        bus(5'h00, 0, 8'h00);
        bus(fsq_pkg::ADR_UNLOCK, 1, 8'hAA);
        bus(fsq_pkg::ADR_CONTROL, 1, 8'h26);
        chk(row[3], 14'h1234);
        unl(8'h22);
        chk(row[3], 14'h1234);
        $display("done: latch load");
        bus(5'h00, 1, 8'h24);
        bus(5'h08, 1, 8'hBC);
        bus(5'h0C, 1, 8'h0A);
        unl(8'h06);
        chk(stall, 1);
        bus(fsq_pkg::ADR_CONTROL, 0, 8'h00);
        chk(q, 8'h84);
        chk(img[3], 14'h1234);
        chk(img[4], 14'h0ABC);
        chk(img[5], 14'h3FFF);
        chk(row[3], 14'h3FFF);
        chk(fad, 15'h0024);
        bus(fsq_pkg::ADR_CONTROL, 1, 8'h01);
        bus(5'h08, 0, 8'h00);
        chk(q, 8'hBC);
        bus(5'h0C, 0, 8'h00);
        chk(q, 8'h1A);
        bus(fsq_pkg::ADR_CONTROL, 0, 8'h00);
        chk(q, 8'h80);
        $display("done: read");
        unl(8'h16);
        chk(stall, 1);
        bus(fsq_pkg::ADR_CONTROL, 0, 8'h00);
        chk({q, n_ops[7:0]}, 16'h8402);
        $display("done: program and erase");
        unl(8'h06);
        repeat (3) @(posedge clock);
        rst_n <= 0;
        repeat (2) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        bus(fsq_pkg::ADR_CONTROL, 0, 8'h00);
        chk(q, 8'h88);
        $display("done: reset in write");
        stop_test();
    end
endmodule : tb_flash_self_write_sequencer
